//--- rtl/sgram_ctrl.sv
`timescale 1ns/1ps
`include "sgram_map.svh"
module sgram_ctrl #(
   parameter int DW = 16,
   parameter int BL = 4,
   parameter logic [1:0] CL = 2'h3,
   parameter int PAUSE_CYCLES = `PAUSE_CYC
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   // memory pins
   sgram_if.ctl MEM,
   // request
   input wire logic REQ_VALID_IN,
   input wire logic REQ_WRITE_IN,
   input wire logic REQ_BLOCK_IN,
   input wire logic REQ_BANK_IN,
   input wire logic [8:0] REQ_ROW_IN,
   input wire logic [7:0] REQ_COL_IN,
   output logic REQ_READY_OUT,
   // write data
   input wire logic [DW-1:0] WDATA_IN,
   input wire logic [DW/8-1:0] WMASK_IN,
   input wire logic [DW-1:0] COLOR_IN,
   output logic WDATA_TAKE_OUT,
   // read data
   output logic [DW-1:0] RDATA_OUT,
   output logic RDATA_VALID_OUT,
   // power
   input wire logic SLEEP_REQ_IN,
   output logic SLEEP_OUT,
   output logic INIT_DONE_OUT
);
   import sgram_pkg::*;
   localparam int GW = `GUARD_W;
   localparam int NB = DW / 8;
   localparam logic [2:0] BL_CODE = (BL == 256) ? `BL_FULL_CODE : 3'($clog2(BL));
   localparam logic [GW-1:0] AGE_LIMIT = GW'(((BL == 256) ? `RASC_CYC : `RAS_MAX_CYC) - `AGE_MARGIN);
   localparam logic [GW-1:0] V_RC = GW'(`RC_CYC);
   localparam logic [GW-1:0] V_RP = GW'(`RP_CYC);
   localparam logic [GW-1:0] V_RCD = GW'(`RCD_CYC);
   localparam logic [GW-1:0] V_RRD = GW'(`RRD_CYC);
   localparam logic [GW-1:0] V_RSA = GW'(`RSA_CYC);
   localparam logic [GW-1:0] V_BWC = GW'(`BWC_CYC);
   localparam logic [GW-1:0] V_RAS = GW'(`RAS_MIN_CYC);
   localparam logic [GW-1:0] V_BWL = GW'(`BWL_CYC);
   localparam logic [GW-1:0] V_SEC = GW'(`SEC_CYC);
   localparam logic [GW-1:0] V_RD_PRE = GW'(BL);
   localparam logic [GW-1:0] V_WR_PRE = GW'(BL - 1 + `RWL_CYC);
   localparam logic [GW-1:0] V_BURST = GW'(BL - 1);

   ctl_state_t state_r, state_nxt;
   logic [GW-1:0] cnt_r, cnt_nxt;
   logic [1:0] open_r;
   logic [8:0] row_r [2];
   logic [GW-1:0] age_r [2];
   cmd_t cmd_r, iss;
   logic [9:0] addr_r, iss_addr;
   logic dsf_r, iss_dsf;
   logic cke_r, cke_nxt;
   logic [NB-1:0] dqm_r, dqm_nxt;
   logic [DW-1:0] dq_r, dq_nxt;
   logic dq_oe_r, dq_oe_nxt;
   logic [DW-1:0] rdata_r;
   logic rvalid_r;
   logic ready, take;
   logic [1:0] act_ok, col_ok, pre_ok, aged;
   logic rrd_ok, any_ok;

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   wire b = REQ_BANK_IN;
   wire hit = open_r[b] && (row_r[b] == REQ_ROW_IN);
   wire aged_bank = !aged[0];
   wire pre_all_ok = ((pre_ok | ~open_r) == 2'b11) && any_ok;
   wire wake = (state_r == ST_SLEEP) && !SLEEP_REQ_IN;
   wire ib = iss_addr[`BANK_BIT];
   wire ipa = iss_addr[`PRE_ALL_BIT];
   wire [9:0] mode_word = 10'((CL << `MR_CL_LSB) | (BL_CODE << `MR_BL_LSB));
   wire [9:0] color_word = 10'h001 << `SMR_COLOR_BIT;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      iss = CMD_NOP;
      iss_addr = 10'h000;
      iss_dsf = 1'b0;
      cke_nxt = 1'b1;
      dq_nxt = '0;
      dq_oe_nxt = 1'b0;
      dqm_nxt = '1;
      ready = 1'b0;
      take = 1'b0;
      unique case (state_r)
         ST_PAUSE: begin
            cnt_nxt = cnt_r - GW'(1);
            if (cnt_r == '0) begin
               state_nxt = ST_MRS;
            end
         end
         ST_MRS: begin
            iss = CMD_MRS;
            iss_addr = mode_word;
            state_nxt = ST_COLOR;
         end
         ST_COLOR: begin
            iss = CMD_MRS;
            iss_dsf = 1'b1;
            iss_addr = color_word;
            dq_nxt = COLOR_IN;
            dq_oe_nxt = 1'b1;
            cnt_nxt = GW'(`INIT_REFS);
            state_nxt = ST_REF;
         end
         ST_REF: begin
            if (rrd_ok) begin
               iss = CMD_REF;
               cnt_nxt = cnt_r - GW'(1);
               if (cnt_r == GW'(1)) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_IDLE: begin
            if (aged != 2'b00) begin
               if (pre_ok[aged_bank] && any_ok) begin
                  iss = CMD_PRE;
                  iss_addr = {aged_bank, 9'h000};
               end
            end else if (SLEEP_REQ_IN) begin
               if (open_r != 2'b00) begin
                  if (pre_all_ok) begin
                     iss = CMD_PRE;
                     iss_addr = 10'h001 << `PRE_ALL_BIT;
                  end
               end else if (act_ok == 2'b11 && any_ok) begin
                  iss = CMD_REF;
                  cke_nxt = 1'b0;
                  state_nxt = ST_SLEEP;
               end
            end else if (REQ_VALID_IN) begin
               if (hit) begin
                  // same row already open in the requested bank: column command at once
                  if (col_ok[b] && any_ok) begin
                     iss = REQ_WRITE_IN ? CMD_WR : CMD_RD;
                     iss_addr = {b, 1'b0, REQ_COL_IN};
                     iss_dsf = REQ_WRITE_IN && REQ_BLOCK_IN;
                     ready = 1'b1;
                     if (REQ_WRITE_IN) begin
                        dq_nxt = WDATA_IN;
                        dq_oe_nxt = 1'b1;
                        dqm_nxt = REQ_BLOCK_IN ? '0 : WMASK_IN;
                        take = 1'b1;
                        if (!REQ_BLOCK_IN && BL > 1) begin
                           cnt_nxt = V_BURST;
                           state_nxt = ST_BURST;
                        end
                     end
                  end
               end else if (open_r[b]) begin
                  if (pre_ok[b] && any_ok) begin
                     iss = CMD_PRE;
                     iss_addr = {b, 9'h000};
                  end
               end else if (act_ok[b] && rrd_ok && any_ok) begin
                  iss = CMD_ACT;
                  iss_addr = {b, REQ_ROW_IN};
               end
            end
         end
         ST_BURST: begin
            dq_nxt = WDATA_IN;
            dq_oe_nxt = 1'b1;
            dqm_nxt = WMASK_IN;
            take = 1'b1;
            cnt_nxt = cnt_r - GW'(1);
            if (cnt_r == GW'(1)) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            cke_nxt = !wake;
            if (wake) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_PAUSE;
         end
      endcase
   end

   // ----------------------------------------
   // interval guards
   // ----------------------------------------
   // counters other than u_col are shared between constraints; each keeps the longest spacing loaded into it
   generate
      for (genvar k = 0; k < 2; k++) begin : g_bank
         wire mine = (ib == 1'(k));
         wire act_k = (iss == CMD_ACT) && mine;
         wire pre_k = (iss == CMD_PRE) && (ipa || mine);
         wire col_k = ((iss == CMD_RD) || (iss == CMD_WR)) && mine;
         wire [GW-1:0] act_val = act_k ? V_RC : V_RP;
         wire [GW-1:0] pre_val = act_k ? V_RAS :
                                 (iss == CMD_RD) ? V_RD_PRE :
                                 iss_dsf ? V_BWL : V_WR_PRE;
         wire [GW-1:0] age_nxt = act_k ? '0 :
                                 (open_r[k] && age_r[k] != '1) ? age_r[k] + GW'(1) : age_r[k];
         sgram_guard #(.W(GW)) u_act (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LOAD_IN(act_k || pre_k),
                                      .VAL_IN(act_val), .OK_OUT(act_ok[k]));
         sgram_guard #(.W(GW)) u_col (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LOAD_IN(act_k),
                                      .VAL_IN(V_RCD), .OK_OUT(col_ok[k]));
         sgram_guard #(.W(GW)) u_pre (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LOAD_IN(act_k || col_k),
                                      .VAL_IN(pre_val), .OK_OUT(pre_ok[k]));
         assign aged[k] = open_r[k] && (age_r[k] >= AGE_LIMIT);
         always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               open_r[k] <= 1'b0;
               row_r[k] <= 9'h000;
               age_r[k] <= '0;
            end else begin
               open_r[k] <= act_k ? 1'b1 : (pre_k ? 1'b0 : open_r[k]);
               row_r[k] <= act_k ? iss_addr[8:0] : row_r[k];
               age_r[k] <= age_nxt;
            end
         end
      end
   endgenerate

   wire rrd_ld = (iss == CMD_ACT) || (iss == CMD_REF) || (iss == CMD_MRS && !iss_dsf);
   wire [GW-1:0] rrd_val = (iss == CMD_ACT) ? V_RRD :
                           (iss == CMD_MRS) ? V_RSA : V_RC;
   wire any_ld = (iss == CMD_WR && iss_dsf) || wake;
   wire [GW-1:0] any_val = wake ? V_SEC : V_BWC;
   sgram_guard #(.W(GW)) u_rrd (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LOAD_IN(rrd_ld),
                                .VAL_IN(rrd_val), .OK_OUT(rrd_ok));
   sgram_guard #(.W(GW)) u_any (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LOAD_IN(any_ld),
                                .VAL_IN(any_val), .OK_OUT(any_ok));

   // ----------------------------------------
   // pin and data registers
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_r <= ST_PAUSE;
         cnt_r <= GW'(PAUSE_CYCLES - 1);
         cmd_r <= CMD_NOP;
         addr_r <= 10'h000;
         dsf_r <= 1'b0;
         cke_r <= 1'b1;
         dqm_r <= '1;
         dq_r <= '0;
         dq_oe_r <= 1'b0;
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cmd_r <= iss;
         addr_r <= iss_addr;
         dsf_r <= iss_dsf;
         cke_r <= cke_nxt;
         dqm_r <= dqm_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
         rvalid_r <= MEM.dq_dev_oe;
         if (MEM.dq_dev_oe) begin
            rdata_r <= MEM.dq_dev;
         end
      end
   end

   assign MEM.cke = cke_r;
   assign MEM.cs_n = 1'b0;
   assign {MEM.ras_n, MEM.cas_n, MEM.we_n} = cmd_r;
   assign MEM.special_function_select = dsf_r;
   assign MEM.addr = addr_r;
   assign MEM.dqm = dqm_r;
   assign MEM.dq_ctl = dq_r;
   assign MEM.dq_ctl_oe = dq_oe_r;
   assign REQ_READY_OUT = ready;
   assign WDATA_TAKE_OUT = take;
   assign RDATA_OUT = rdata_r;
   assign RDATA_VALID_OUT = rvalid_r;
   assign SLEEP_OUT = (state_r == ST_SLEEP);
   assign INIT_DONE_OUT = (state_r == ST_IDLE) || (state_r == ST_BURST) || (state_r == ST_SLEEP);
endmodule

//--- rtl/sgram_device.sv
`timescale 1ns/1ps
`include "sgram_map.svh"
module sgram_device #(parameter int DW = 16, parameter int DEPTH_LOG = 6) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   // memory pins
   sgram_if.dev PINS,
   // status
   output logic [1:0] BANK_OPEN_OUT,
   output logic [1:0] CAS_LAT_OUT,
   output logic BURSTING_OUT
);
   import sgram_pkg::*;
   localparam int NB = DW / 8;
   localparam int CW = DEPTH_LOG - 1;
   localparam int DEPTH = 1 << DEPTH_LOG;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic [1:0] open_r;
   logic [1:0] cl_r;
   logic [2:0] bl_code_r;
   logic [DW-1:0] color_r;
   logic [7:0] col_r;
   logic cur_bank_r;
   logic [8:0] rd_left_r;
   logic [8:0] wr_left_r;
   logic [2:0] pv_r;
   logic [DW-1:0] pd_r [3];
   logic [DW-1:0] mem_r [DEPTH];
   cmd_t cmd;

   // clock enable (cke) held low masks every command
   assign cmd = PINS.cke ? cmd_of(PINS.cs_n, {PINS.ras_n, PINS.cas_n, PINS.we_n}) : CMD_NOP;
   wire bank = PINS.addr[`BANK_BIT];
   wire pre_hit = (cmd == CMD_PRE) && (PINS.addr[`PRE_ALL_BIT] || bank == cur_bank_r);
   wire col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
   // any new column command, stop, or precharge of the burst bank or of all banks ends the running burst
   wire term = col_cmd || (cmd == CMD_BST) || pre_hit;
   wire fetch = (cmd == CMD_RD) || (rd_left_r != 9'h0 && !term);
   wire wr_burst = (cmd == CMD_WR && !PINS.special_function_select) || (wr_left_r != 9'h0 && !term);
   wire blk_wr = (cmd == CMD_WR) && PINS.special_function_select;
   wire [7:0] col = col_cmd ? PINS.addr[7:0] : col_r;
   wire b_sel = col_cmd ? bank : cur_bank_r;
   wire [DEPTH_LOG-1:0] idx = {b_sel, col[CW-1:0]};
   wire [8:0] bl_words = burst_words(bl_code_r);
   wire [8:0] left = bl_words - 9'h001;
   wire [7:0] wrap = left[7:0];
   wire [7:0] col_inc = (col & ~wrap) | ((col + 8'h01) & wrap);
   wire [1:0] bank_mask = 2'b01 << bank;

   wire [8:0] rd_left_nxt = (cmd == CMD_RD) ? left : (fetch ? rd_left_r - 9'h001 : 9'h000);
   wire [8:0] wr_left_nxt = (cmd == CMD_WR && !PINS.special_function_select) ? left :
                            (wr_burst ? wr_left_r - 9'h001 : 9'h000);
   wire [7:0] col_nxt = (fetch || wr_burst) ? col_inc : col_r;
   wire [1:0] open_nxt = (cmd == CMD_ACT) ? (open_r | bank_mask) :
                         (cmd == CMD_PRE) ? (PINS.addr[`PRE_ALL_BIT] ? 2'b00 : (open_r & ~bank_mask)) :
                         open_r;
   wire mode_ld = (cmd == CMD_MRS) && !PINS.special_function_select && (open_r == 2'b00);
   wire color_ld = (cmd == CMD_MRS) && PINS.special_function_select && PINS.addr[`SMR_COLOR_BIT];
   // latency code zero is illegal and is served as latency one
   wire [1:0] stage = (cl_r == 2'h0) ? 2'h0 : cl_r - 2'h1;

   // ----------------------------------------
   // control state
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         open_r <= 2'b00;
         cl_r <= `CL_RESET;
         bl_code_r <= 3'h0;
         color_r <= '0;
         col_r <= 8'h00;
         cur_bank_r <= 1'b0;
         rd_left_r <= 9'h000;
         wr_left_r <= 9'h000;
         pv_r <= 3'h0;
      end else begin
         open_r <= open_nxt;
         if (mode_ld) begin
            cl_r <= PINS.addr[`MR_CL_LSB +: 2];
            bl_code_r <= PINS.addr[`MR_BL_LSB +: 3];
         end
         if (color_ld) begin
            color_r <= PINS.dq_ctl;
         end
         col_r <= col_nxt;
         cur_bank_r <= b_sel;
         rd_left_r <= rd_left_nxt;
         wr_left_r <= wr_left_nxt;
         pv_r <= {pv_r[1:0], fetch};
      end
   end

   // ----------------------------------------
   // storage and read pipe
   // ----------------------------------------
   always_ff @(posedge CLK_IN) begin
      pd_r[0] <= mem_r[idx];
      pd_r[1] <= pd_r[0];
      pd_r[2] <= pd_r[1];
   end

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_word
         // block write fills eight aligned columns, each enabled by one data bit
         wire blk_hit = blk_wr && ({bank, PINS.addr[CW-1:3]} == (DEPTH_LOG - 3)'(i >> 3)) &&
                        PINS.dq_ctl[i % 8];
         wire hit = wr_burst && (idx == DEPTH_LOG'(i));
         for (genvar b = 0; b < NB; b++) begin : g_byte
            always_ff @(posedge CLK_IN) begin
               if (hit && !PINS.dqm[b]) begin
                  mem_r[i][b*8 +: 8] <= PINS.dq_ctl[b*8 +: 8];
               end else if (blk_hit && !PINS.dqm[b]) begin
                  mem_r[i][b*8 +: 8] <= color_r[b*8 +: 8];
               end
            end
         end
      end
   endgenerate

   assign PINS.dq_dev = pd_r[stage];
   assign PINS.dq_dev_oe = pv_r[stage];
   assign BANK_OPEN_OUT = open_r;
   assign CAS_LAT_OUT = cl_r;
   assign BURSTING_OUT = (rd_left_r != 9'h000) || (wr_left_r != 9'h000);
endmodule

//--- rtl/sgram_guard.sv
`timescale 1ns/1ps
module sgram_guard #(parameter int W = 13) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   // load a spacing of VAL_IN cycles from this one
   input wire logic LOAD_IN,
   input wire logic [W-1:0] VAL_IN,
   // next command allowed
   output logic OK_OUT
);
   logic [W-1:0] rem_r;
   // a shorter new interval never cuts a longer one still running
   wire [W-1:0] dec = (rem_r != '0) ? rem_r - W'(1) : '0;
   wire [W-1:0] want = (VAL_IN != '0) ? VAL_IN - W'(1) : '0;
   wire [W-1:0] rem_nxt = (LOAD_IN && want > dec) ? want : dec;

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rem_r <= '0;
      end else begin
         rem_r <= rem_nxt;
      end
   end
   assign OK_OUT = (rem_r == '0);
endmodule

//--- rtl/sgram_if.sv
`timescale 1ns/1ps
interface sgram_if #(parameter int DW = 16);
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic special_function_select;
   logic [9:0] addr;
   logic [DW/8-1:0] dqm;
   logic [DW-1:0] dq_ctl;
   logic dq_ctl_oe;
   logic [DW-1:0] dq_dev;
   logic dq_dev_oe;
   // shared data bus level as seen on the board
   wire [DW-1:0] dq = dq_ctl_oe ? dq_ctl : dq_dev;

   modport dev(input cke, cs_n, ras_n, cas_n, we_n, special_function_select, addr, dqm, dq_ctl, dq_ctl_oe,
               output dq_dev, dq_dev_oe);
   modport ctl(output cke, cs_n, ras_n, cas_n, we_n, special_function_select, addr, dqm, dq_ctl, dq_ctl_oe,
               input dq_dev, dq_dev_oe);
endinterface

//--- rtl/sgram_map.svh
`ifndef SGRAM_MAP_SVH
`define SGRAM_MAP_SVH

// ----------------------------------------
// timing, 50 MHz clock
// ----------------------------------------
`define CLK_NS 20
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_RC_NS 100
`define T_RP_NS 34
`define T_RCD_NS 25
`define T_RRD_NS 25
`define T_RSA_NS 25
`define T_BWC_NS 25
`define T_RWL_NS 25
`define T_RAS_MIN_NS 65
`define T_RAS_MAX_NS 10000
`define T_RASC_NS 80000
`define T_PAUSE_US 100
`define RC_CYC `CYC_UP(`T_RC_NS)
`define RP_CYC `CYC_UP(`T_RP_NS)
`define RCD_CYC `CYC_UP(`T_RCD_NS)
`define RRD_CYC `CYC_UP(`T_RRD_NS)
`define RSA_CYC `CYC_UP(`T_RSA_NS)
`define BWC_CYC `CYC_UP(`T_BWC_NS)
`define RWL_CYC `CYC_UP(`T_RWL_NS)
`define RAS_MIN_CYC `CYC_UP(`T_RAS_MIN_NS)
`define RAS_MAX_CYC (`T_RAS_MAX_NS / `CLK_NS)
`define RASC_CYC (`T_RASC_NS / `CLK_NS)
`define PAUSE_CYC `CYC_UP(`T_PAUSE_US * 1000)
`define BWL_CYC (`RWL_CYC + 1)
`define SEC_CYC `RC_CYC
`define AGE_MARGIN 16
`define INIT_REFS 8

// ----------------------------------------
// address fields
// ----------------------------------------
`define MR_CL_LSB 4
`define MR_BL_LSB 0
`define SMR_COLOR_BIT 6
`define PRE_ALL_BIT 8
`define BANK_BIT 9
`define BL_FULL_CODE 3'h7
`define GUARD_W 13
`define CL_RESET 2'h1
`endif

//--- rtl/sgram_pkg.sv
`include "sgram_map.svh"
package sgram_pkg;
   typedef enum logic [2:0] {
      CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
      CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
   } cmd_t;
   typedef enum logic [2:0] {
      ST_PAUSE = 3'h0, ST_MRS = 3'h1, ST_COLOR = 3'h3, ST_REF = 3'h2,
      ST_IDLE = 3'h6, ST_BURST = 3'h7, ST_SLEEP = 3'h4
   } ctl_state_t;

   function automatic cmd_t cmd_of(input logic cs_n, input logic [2:0] rcw_n);
      cmd_of = cs_n ? CMD_NOP : cmd_t'(rcw_n);
   endfunction

   function automatic logic [8:0] burst_words(input logic [2:0] code);
      burst_words = (code == `BL_FULL_CODE) ? 9'h100 : (9'h001 << code);
   endfunction
endpackage

//--- verif/sgram_checker.sv
`timescale 1ns/1ps
module sgram_checker
   import sgram_pkg::*;
   #(parameter int PAUSE = 20) (
   // board pins
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic special_function_select,
   input wire logic [9:0] addr,
   input wire logic dq_ctl_oe,
   input wire logic dq_dev_oe
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   cmd_t cmd;
   logic [15:0] age_r;
   assign cmd = cs_n ? CMD_NOP : cmd_t'({ras_n, cas_n, we_n});
   wire act = cmd == CMD_ACT;
   wire pre = cmd == CMD_PRE;
   wire col = cmd == CMD_RD || cmd == CMD_WR;
   wire bwr = cmd == CMD_WR && special_function_select;
   // saturates so a long run never wraps back into the pause window
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) age_r <= 16'h0000;
      else if (age_r != 16'hFFFF) age_r <= age_r + 16'h0001;
   end
   sequence s_quiet;
      cmd == CMD_NOP;
   endsequence
   // each step looks back to the activate that started the window
   property p_act_same;
      act |=> !(act && addr[9] == $past(addr[9], 1)) ##1 !(act && addr[9] == $past(addr[9], 2))
              ##1 !(act && addr[9] == $past(addr[9], 3)) ##1 !(act && addr[9] == $past(addr[9], 4));
   endproperty
   a_pause_quiet: assert property (age_r < 16'(PAUSE - 2) |-> s_quiet)
      else $error("command during power-up pause");
   a_act_same_bank: assert property (p_act_same)
      else $error("same bank activated too soon");
   a_act_any_bank: assert property (act |=> !act)
      else $error("activates too close");
   a_act_to_col: assert property (act |=> !(col && addr[9] == $past(addr[9])))
      else $error("column too soon after activate");
   a_pre_to_act: assert property (pre |=> !(act && ($past(addr[8]) || addr[9] == $past(addr[9]))))
      else $error("activate too soon after precharge");
   a_mode_to_act: assert property (cmd == CMD_MRS |=> !act)
      else $error("activate too soon after mode set");
   a_wr_data_now: assert property (cmd == CMD_WR |-> dq_ctl_oe)
      else $error("write data missing with command");
   a_bwr_quiet: assert property (bwr |=> s_quiet)
      else $error("command inside block write cycle");
   a_bwr_to_pre: assert property (bwr |-> ##2 !(pre && addr[9] == $past(addr[9], 2)))
      else $error("precharge too soon after block write");
   a_rd_first_word: assert property (cmd == CMD_RD |-> ##3 dq_dev_oe)
      else $error("read data not driven at latency");
   a_exit_quiet: assert property ($rose(cke) |-> s_quiet[*4])
      else $error("command too soon after self refresh exit");
endmodule

//--- verif/sgram_command_interval_timing_tb_top.sv
`timescale 1ns/1ps
module sgram_command_interval_timing_tb_top;
   import sgram_pkg::*;
   logic CLK_IN = 1'b0;
   logic RSTN_IN = 1'b0;
   logic vld = 1'b0, wr = 1'b0, blk = 1'b0, bank = 1'b0, sleep = 1'b0, mask_on = 1'b0;
   logic [8:0] row = 9'h000;
   logic [7:0] col = 8'h00;
   logic [15:0] wdata = 16'h0000, color = 16'h5AC3;
   logic [1:0] wmask = 2'h0;
   wire ready, take, rvalid, slept, done, bursting;
   wire [15:0] rdata;
   wire [1:0] cas_lat, open_banks;
   logic [15:0] mem [64];
   logic [15:0] expq [$];
   int fails = 0, total_checks = 0, cyc = 0, last_rd = -8;
   sgram_if #(.DW(16)) bus_if ();
   sgram_ctrl #(.PAUSE_CYCLES(20)) sgram_ctrl_inst (.CLK_IN, .RSTN_IN, .MEM(bus_if.ctl), .REQ_VALID_IN(vld),
      .REQ_WRITE_IN(wr), .REQ_BLOCK_IN(blk), .REQ_BANK_IN(bank), .REQ_ROW_IN(row), .REQ_COL_IN(col),
      .REQ_READY_OUT(ready), .WDATA_IN(wdata), .WMASK_IN(wmask), .COLOR_IN(color), .WDATA_TAKE_OUT(take),
      .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid), .SLEEP_REQ_IN(sleep), .SLEEP_OUT(slept), .INIT_DONE_OUT(done));
   sgram_device sgram_device_inst (.CLK_IN, .RSTN_IN, .PINS(bus_if.dev), .BANK_OPEN_OUT(open_banks),
      .CAS_LAT_OUT(cas_lat), .BURSTING_OUT(bursting));
   sgram_checker #(.PAUSE(20)) sgram_checker_inst (.CLK_IN, .RSTN_IN, .cke(bus_if.cke), .cs_n(bus_if.cs_n),
      .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .special_function_select(bus_if.special_function_select), .addr(bus_if.addr),
      .dq_ctl_oe(bus_if.dq_ctl_oe), .dq_dev_oe(bus_if.dq_dev_oe));
   initial forever #10 CLK_IN = ~CLK_IN;
   // ----------------------------------------
   // checking and driving helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] d, input logic [1:0] m);
      return {m[1] ? o[15:8] : d[15:8], m[0] ? o[7:0] : d[7:0]};
   endfunction
   // entered at a falling edge; samples 1 ns ahead of the rising edge so comb pulses are settled
   task automatic req(input logic w, input logic k, input logic b, input logic [8:0] r, input logic [7:0] c);
      int n = 0;
      int t;
      logic got = 1'b0;
      {vld, wr, blk, bank, row, col} = {1'b1, w, k && w, b, r, c};
      for (t = 0; t < 400; t++) begin
         // data holds while the request waits; a fresh word only after one is taken
         if (t == 0 || n > 0) begin
            wdata = 16'($urandom);
            wmask = (mask_on && !k) ? 2'($urandom) : 2'h0;
         end
         #9;
         if (take === 1'b1) begin
            if (k) begin
               for (int i = 0; i < 8; i++) if (wdata[i]) mem[{b, c[4:3], 3'(i)}] = color;
            end else mem[{b, c[4:2], 2'(c[1:0] + n)}] = mrg(mem[{b, c[4:2], 2'(c[1:0] + n)}], wdata, wmask);
            n++;
         end
         if (ready === 1'b1) begin
            got = 1'b1;
            // a column command inside the last read burst cuts it: drop the words never sent
            if (cyc - last_rd < 4) repeat (4 - (cyc - last_rd)) void'(expq.pop_back());
            last_rd = w ? -8 : cyc;
            if (!w) for (int i = 0; i < 4; i++) expq.push_back(mem[{b, c[4:2], 2'(c[1:0] + i)}]);
         end
         @(negedge CLK_IN);
         if (got && w) vld = 1'b0;
         if (got && n >= (w ? (k ? 1 : 4) : 0)) break;
      end
      if (t == 400) check(16'h0000, 16'h0001);
      if (w) @(negedge CLK_IN);
   endtask
   always @(negedge CLK_IN) begin
      if (rvalid === 1'b1 && expq.size() > 0) check(rdata, expq.pop_front());
      else if (rvalid === 1'b1) check(16'h0000, 16'h0001);
   end
   always @(posedge CLK_IN) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      int t;
      void'($urandom(32'h64fa01e7));
      repeat (12) @(posedge CLK_IN);
      @(negedge CLK_IN);
      RSTN_IN = 1'b1;
      for (t = 0; t < 3000 && done !== 1'b1; t++) @(negedge CLK_IN);
      check({15'h0000, done}, 16'h0001);
      check({14'h0000, cas_lat}, 16'h0003);
      $display("test init done");
      for (int g = 0; g < 16; g++) req(1'b1, 1'b0, g[3], 9'h000, {3'($urandom), g[2:0], 2'h0});
      mask_on = 1'b1;
      // block write followed at once by a read of the other bank
      req(1'b1, 1'b1, 1'b0, 9'h001, 8'h00);
      req(1'b0, 1'b0, 1'b1, 9'h000, 8'h05);
      $display("test fill done");
      for (int i = 0; i < 300; i++)
         req(1'($urandom), $urandom_range(7) == 0, 1'($urandom), 9'($urandom_range(3)), 8'($urandom));
      vld = 1'b0;
      $display("test random done");
      sleep = 1'b1;
      for (t = 0; t < 500 && slept !== 1'b1; t++) @(negedge CLK_IN);
      check({15'h0000, slept}, 16'h0001);
      check({13'h0000, bursting, open_banks}, 16'h0000);
      sleep = 1'b0;
      for (t = 0; t < 500 && slept !== 1'b0; t++) @(negedge CLK_IN);
      for (int i = 0; i < 8; i++) req(1'b0, 1'b0, i[0], 9'h002, 8'(i * 4));
      vld = 1'b0;
      repeat (20) @(negedge CLK_IN);
      check(16'(expq.size()), 16'h0000);
      check({14'h0000, open_banks}, 16'h0003);
      $display("test sleep done");
      final_report();
   end
endmodule
